// ### core/memory_space_access_decode.sv
// program and data space address decode, lane steering and alignment trap
// Behaviour
// - program addresses are 24 bits from three sources
// - user program accesses stay below 0x800000
// - table ops reach configuration via page bit 7
// - even address lower word, odd upper word
// - pointer word-aligned, steps by two
// - reset fetch at zero, jump then target
// - primary and alternate vector tables decoded
// - read and write generators are independent
// - effective address is 16-bit byte address
// - top address bit selects visibility window
// - reads from 16 Kbytes up to the visibility window return zero
// - low byte even, high byte odd
// - post-increment adds one byte, two word
// - byte read selects lane onto low byte
// - byte write strobes only matching lane
// - odd word access raises address trap
// - misaligned read completes, misaligned write suppressed
// - byte load keeps working register high byte
// - sign and zero extension of low byte
// - special register region reads zero if unused
`timescale 1ns/1ns
`default_nettype none
module memory_space_access_decode (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // instruction pointer control
    input wire logic i_ip_advance,
    input wire logic i_ip_retreat,
    input wire logic i_ip_load,
    input wire logic [22:0] i_ip_target,
    // program space access
    input wire memory_space_pkg::prog_source_type i_prog_source,
    input wire logic [7:0] i_table_page_pointer,
    input wire logic [15:0] i_table_offset,
    input wire logic [7:0] i_visibility_page,
    input wire logic [15:0] i_remap_ea,
    input wire logic [23:0] i_prog_instr,
    // data read generator
    input wire memory_space_pkg::data_rd_req_type i_rd_req,
    input wire logic [15:0] i_rd_word,
    input wire logic i_sfr_present,
    input wire logic i_visibility_enable,
    input wire logic [15:0] i_visibility_word,
    // data write generator
    input wire memory_space_pkg::data_wr_req_type i_wr_req,
    // working register load path
    input wire memory_space_pkg::wreg_load_type i_wreg_load,
    input wire logic [15:0] i_wreg_old,
    // program side outputs
    output logic [22:0] o_instruction_pointer,
    output logic [23:0] o_prog_addr,
    output logic o_prog_config_access,
    output logic o_prog_user_violation,
    output memory_space_pkg::vector_class_type o_prog_vector_class,
    output logic [15:0] o_prog_word,
    // data read outputs
    output logic o_rd_valid,
    output logic [14:0] o_rd_word_addr,
    output logic [15:0] o_rd_next_ea,
    output logic o_rd_data_valid,
    output logic [15:0] o_rd_data,
    output logic o_rd_trap,
    // data write outputs
    output logic [14:0] o_wr_word_addr,
    output logic [1:0] o_wr_strobe,
    output logic [15:0] o_wr_data,
    output logic [15:0] o_wr_next_ea,
    output logic o_wr_trap,
    // working register outputs
    output logic o_wreg_valid,
    output logic [15:0] o_wreg_new
);
    import memory_space_pkg::*;

    // region of a data effective address
    function automatic region_type region_of(input logic [15:0] ea);
        if (ea[VISIBILITY_BIT]) begin
            region_of = REG_VISIBILITY;
        end else if (ea <= SFR_LAST) begin
            region_of = REG_SFR;
        end else if (ea <= RAM_LAST) begin
            region_of = REG_RAM;
        end else begin
            region_of = REG_UNIMPL;
        end
    endfunction

    // post-modify step scaled by operand size
    function automatic logic [15:0] post_step(input logic [15:0] ea, input logic byte_op);
        post_step = ea + (byte_op ? BYTE_STEP : WORD_STEP);
    endfunction

    // word access at an odd byte address
    function automatic logic misaligned(input logic byte_op, input logic [15:0] ea);
        misaligned = !byte_op && ea[0];
    endfunction

    // registers
    logic [22:0] ip_q, ip_d;
    logic [23:0] prog_addr_q, prog_addr_d;
    logic prog_config_q, prog_violation_q;
    vector_class_type vec_class_q, vec_class_d;
    logic [15:0] prog_word_q, prog_word_d;
    logic rd_valid_q, rd_byte_q, rd_hi_q, rd_mis_q;
    region_type rd_region_q;
    logic [14:0] rd_word_addr_q;
    logic [15:0] rd_next_ea_q;
    logic rd_data_valid_q, rd_trap_q;
    logic [15:0] rd_data_q, rd_data_d;
    logic [14:0] wr_word_addr_q;
    logic [1:0] wr_strobe_q, wr_strobe_d;
    logic [15:0] wr_data_q, wr_next_ea_q;
    logic wr_trap_q;
    logic wreg_valid_q;
    logic [15:0] wreg_new_q, wreg_new_d;

    // instruction pointer stepping, kept on the lower word
    wire [22:0] ip_step_up = ip_q + IP_STEP;
    wire [22:0] ip_step_down = ip_q - IP_STEP;
    assign ip_d = i_ip_load ? {i_ip_target[22:1], 1'b0} :
                  i_ip_advance ? ip_step_up :
                  i_ip_retreat ? ip_step_down : ip_q;

    // program address source selection
    wire [23:0] exec_addr = {1'b0, ip_q};
    wire [23:0] table_addr = {i_table_page_pointer, i_table_offset};
    wire [23:0] remap_addr = {1'b0, i_visibility_page, i_remap_ea[14:0]};
    assign prog_addr_d = (i_prog_source == SRC_TABLE) ? table_addr :
                         (i_prog_source == SRC_REMAP) ? remap_addr : exec_addr;
    wire table_config = (i_prog_source == SRC_TABLE) && i_table_page_pointer[CONFIG_PAGE_BIT];
    wire user_violation = (i_prog_source != SRC_TABLE) && (prog_addr_d > USER_SPACE_TOP);

    // vector region classification
    wire [23:0] pa = prog_addr_d;
    assign vec_class_d = (pa == RESET_JUMP_LOC) ? VEC_RESET_JUMP :
                         (pa == RESET_TARGET_LOC) ? VEC_RESET_TARGET :
                         (pa >= PRIMARY_TABLE_START && pa <= PRIMARY_TABLE_END) ? VEC_PRIMARY :
                         (pa >= ALTERNATE_TABLE_START && pa <= ALTERNATE_TABLE_END) ?
                         VEC_ALTERNATE : VEC_NONE;

    // program word lane: odd address takes upper word, its top byte absent
    assign prog_word_d = prog_addr_q[0] ?
                         {8'h00, i_prog_instr[PROG_UPPER_BYTE_LSB +: 8]} :
                         i_prog_instr[15:0];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ip_q <= IP_RESET_VALUE;
            prog_addr_q <= RESET_JUMP_LOC;
            prog_config_q <= 1'b0;
            prog_violation_q <= 1'b0;
            vec_class_q <= VEC_RESET_JUMP;
            prog_word_q <= 16'h0000;
        end else begin
            ip_q <= ip_d;
            prog_addr_q <= prog_addr_d;
            prog_config_q <= table_config;
            prog_violation_q <= user_violation;
            vec_class_q <= vec_class_d;
            prog_word_q <= prog_word_d;
        end
    end

    // read generator: decode request, word address shared by both lanes
    region_type rd_region;
    assign rd_region = region_of(i_rd_req.ea);
    wire rd_mis = i_rd_req.valid && misaligned(i_rd_req.byte_op, i_rd_req.ea);

    // read data: zero outside implemented space, lane steered to low byte
    wire [15:0] rd_src = (rd_region_q == REG_RAM) ? i_rd_word :
                         (rd_region_q == REG_SFR && i_sfr_present) ? i_rd_word :
                         (rd_region_q == REG_VISIBILITY && i_visibility_enable) ?
                         i_visibility_word : 16'h0000;
    assign rd_data_d = rd_byte_q ?
                       {8'h00, (rd_hi_q ? rd_src[15:8] : rd_src[7:0])} : rd_src;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_valid_q <= 1'b0;
            rd_byte_q <= 1'b0;
            rd_hi_q <= 1'b0;
            rd_mis_q <= 1'b0;
            rd_region_q <= REG_SFR;
            rd_word_addr_q <= 15'h0000;
            rd_next_ea_q <= 16'h0000;
        end else begin
            rd_valid_q <= i_rd_req.valid;
            rd_byte_q <= i_rd_req.byte_op;
            rd_hi_q <= i_rd_req.ea[0];
            rd_mis_q <= rd_mis;
            rd_region_q <= rd_region;
            if (i_rd_req.valid) begin
                rd_word_addr_q <= i_rd_req.ea[15:1];
                rd_next_ea_q <= post_step(i_rd_req.ea, i_rd_req.byte_op);
            end
        end
    end

    // read completion, trap raised with the completed data
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
            rd_trap_q <= 1'b0;
        end else begin
            rd_data_valid_q <= rd_valid_q;
            rd_trap_q <= rd_valid_q && rd_mis_q;
            if (rd_valid_q) begin
                rd_data_q <= rd_data_d;
            end
        end
    end

    // write generator: per-lane strobes, store dropped when misaligned
    region_type wr_region;
    assign wr_region = region_of(i_wr_req.ea);
    wire wr_mis = i_wr_req.valid && misaligned(i_wr_req.byte_op, i_wr_req.ea);
    wire wr_target = (wr_region == REG_SFR) || (wr_region == REG_RAM);
    wire [1:0] wr_lanes = i_wr_req.byte_op ? (i_wr_req.ea[0] ? LANE_HIGH : LANE_LOW) :
                          LANE_BOTH;
    assign wr_strobe_d = (i_wr_req.valid && wr_target && !wr_mis) ? wr_lanes : LANE_NONE;
    wire [15:0] wr_data_d = i_wr_req.byte_op ? {2{i_wr_req.data[7:0]}} : i_wr_req.data;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_word_addr_q <= 15'h0000;
            wr_strobe_q <= LANE_NONE;
            wr_data_q <= 16'h0000;
            wr_next_ea_q <= 16'h0000;
            wr_trap_q <= 1'b0;
        end else begin
            wr_strobe_q <= wr_strobe_d;
            wr_trap_q <= wr_mis;
            if (i_wr_req.valid) begin
                wr_word_addr_q <= i_wr_req.ea[15:1];
                wr_data_q <= wr_data_d;
                wr_next_ea_q <= post_step(i_wr_req.ea, i_wr_req.byte_op);
            end
        end
    end

    // working register merge and extension
    wire [15:0] sign_ext = {{8{i_wreg_old[7]}}, i_wreg_old[7:0]};
    wire [15:0] zero_ext = {8'h00, i_wreg_old[7:0]};
    wire [15:0] byte_merge = {i_wreg_old[15:8], i_wreg_load.data[7:0]};
    assign wreg_new_d = (i_wreg_load.ext == EXT_SIGN) ? sign_ext :
                        (i_wreg_load.ext == EXT_ZERO) ? zero_ext :
                        i_wreg_load.byte_op ? byte_merge : i_wreg_load.data;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wreg_valid_q <= 1'b0;
            wreg_new_q <= 16'h0000;
        end else begin
            wreg_valid_q <= i_wreg_load.valid;
            if (i_wreg_load.valid) begin
                wreg_new_q <= wreg_new_d;
            end
        end
    end

    // outputs straight from flip-flops
    assign o_instruction_pointer = ip_q;
    assign o_prog_addr = prog_addr_q;
    assign o_prog_config_access = prog_config_q;
    assign o_prog_user_violation = prog_violation_q;
    assign o_prog_vector_class = vec_class_q;
    assign o_prog_word = prog_word_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_word_addr = rd_word_addr_q;
    assign o_rd_next_ea = rd_next_ea_q;
    assign o_rd_data_valid = rd_data_valid_q;
    assign o_rd_data = rd_data_q;
    assign o_rd_trap = rd_trap_q;
    assign o_wr_word_addr = wr_word_addr_q;
    assign o_wr_strobe = wr_strobe_q;
    assign o_wr_data = wr_data_q;
    assign o_wr_next_ea = wr_next_ea_q;
    assign o_wr_trap = wr_trap_q;
    assign o_wreg_valid = wreg_valid_q;
    assign o_wreg_new = wreg_new_q;

    // checks on the decode
    ip_aligned_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !ip_q[0])
        else $error("instruction pointer off the lower word");
    ip_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ip_advance && !i_ip_load) |=> ip_q == $past(ip_q) + IP_STEP)
        else $error("instruction pointer step wrong");
    ip_retreat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ip_retreat && !i_ip_advance && !i_ip_load) |=>
        ip_q == $past(ip_q) - IP_STEP)
        else $error("instruction pointer retreat wrong");
    table_config_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_prog_source == SRC_TABLE && i_table_page_pointer[7]) |=> o_prog_config_access)
        else $error("table op missed configuration region");
    user_space_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_prog_source != SRC_TABLE) |=> !o_prog_addr[23])
        else $error("user access left lower half");
    upper_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_prog_addr[0] |=> o_prog_word[15:8] == 8'h00)
        else $error("upper word top byte not zero");
    read_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd_req.valid && i_rd_req.ea[15:14] == 2'b01) |-> ##2 o_rd_data == 16'h0000)
        else $error("unimplemented read not zero");
    byte_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd_req.valid && i_rd_req.byte_op) |-> ##2 o_rd_data[15:8] == 8'h00)
        else $error("byte read high byte not clear");
    read_trap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd_req.valid && !i_rd_req.byte_op && i_rd_req.ea[0]) |->
        ##2 (o_rd_trap && o_rd_data_valid))
        else $error("misaligned read did not complete and trap");
    write_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_req.valid && !i_wr_req.byte_op && i_wr_req.ea[0]) |=>
        (o_wr_trap && o_wr_strobe == 2'h0))
        else $error("misaligned write not suppressed");
    byte_lane_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_req.valid && i_wr_req.byte_op && i_wr_req.ea[15:14] == 2'b00) |=>
        o_wr_strobe == ($past(i_wr_req.ea[0]) ? 2'h2 : 2'h1))
        else $error("byte write strobe on wrong lane");
    post_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd_req.valid |=> o_rd_next_ea ==
        $past(i_rd_req.ea) + ($past(i_rd_req.byte_op) ? 16'h0001 : 16'h0002))
        else $error("post increment step wrong");
    byte_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wreg_load.valid && i_wreg_load.byte_op && i_wreg_load.ext == EXT_NONE) |=>
        o_wreg_new[15:8] == $past(i_wreg_old[15:8]))
        else $error("byte load altered high byte");
    reset_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_prog_source == SRC_EXEC && o_instruction_pointer == 23'h000000) |=>
        (o_prog_addr == 24'h000000 && o_prog_vector_class == VEC_RESET_JUMP))
        else $error("reset location not decoded as jump");
    primary_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_prog_source == SRC_EXEC && o_instruction_pointer >= 23'h000004 &&
        o_instruction_pointer <= 23'h0000FF) |=> o_prog_vector_class == VEC_PRIMARY)
        else $error("primary vector table not decoded");
    word_lanes_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_req.valid && !i_wr_req.byte_op && !i_wr_req.ea[0] &&
        i_wr_req.ea[15:14] == 2'h0) |=> o_wr_strobe == 2'h3)
        else $error("aligned word write missed a lane");
    zero_extend_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wreg_load.valid && i_wreg_load.ext == EXT_ZERO) |=>
        o_wreg_new == {8'h00, $past(i_wreg_old[7:0])})
        else $error("zero extension left high byte");
    word_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd_req.valid |=> o_rd_word_addr == $past(i_rd_req.ea[15:1]))
        else $error("read word address not ea without bit zero");
endmodule // memory_space_access_decode
`default_nettype wire

// ### core/memory_space_pkg.sv
// shared constants, enumerations and carriers of the memory space decoder
package memory_space_pkg;
    // program space
    localparam int PROG_ADDR_W = 24;
    localparam int IP_W = 23;
    localparam logic [23:0] USER_SPACE_TOP = 24'h7FFFFF;
    localparam logic [22:0] IP_RESET_VALUE = 23'h000000;
    localparam logic [22:0] IP_STEP = 23'h000002;
    localparam logic [23:0] RESET_JUMP_LOC = 24'h000000;
    localparam logic [23:0] RESET_TARGET_LOC = 24'h000002;
    localparam logic [23:0] PRIMARY_TABLE_START = 24'h000004;
    localparam logic [23:0] PRIMARY_TABLE_END = 24'h0000FF;
    localparam logic [23:0] ALTERNATE_TABLE_START = 24'h000100;
    localparam logic [23:0] ALTERNATE_TABLE_END = 24'h0001FF;
    localparam int CONFIG_PAGE_BIT = 7;
    localparam int PROG_UPPER_BYTE_LSB = 16;
    // data space
    localparam int EA_W = 16;
    localparam int VISIBILITY_BIT = 15;
    localparam logic [15:0] SFR_LAST = 16'h07FF;
    localparam logic [15:0] RAM_LAST = 16'h3FFF;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [1:0] LANE_NONE = 2'h0;
    localparam logic [1:0] LANE_LOW = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [1:0] LANE_BOTH = 2'h3;

    typedef enum logic [1:0] {SRC_EXEC, SRC_TABLE, SRC_REMAP} prog_source_type;
    typedef enum logic [2:0] {
        VEC_RESET_JUMP, VEC_RESET_TARGET, VEC_PRIMARY, VEC_ALTERNATE, VEC_NONE
    } vector_class_type;
    typedef enum logic [1:0] {REG_SFR, REG_RAM, REG_UNIMPL, REG_VISIBILITY} region_type;
    typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} extend_type;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [15:0] ea;
    } data_rd_req_type;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [15:0] ea;
        logic [15:0] data;
    } data_wr_req_type;

    typedef struct packed {
        logic valid;
        logic byte_op;
        extend_type ext;
        logic [15:0] data;
    } wreg_load_type;
endpackage

// ### sim/cpu_side_model.sv
// cpu side model answering program and data word fetches of the decoder
`timescale 1ns/1ns
`default_nettype none
module cpu_side_model (
    input wire logic [23:0] i_prog_addr,
    input wire logic [14:0] i_rd_word_addr,
    output logic [23:0] o_prog_instr,
    output logic [15:0] o_rd_word,
    output logic [15:0] o_visibility_word
);
    // program and data words are a fixed pattern of their address, the visibility word a constant, so every fetch is predictable
    assign o_prog_instr = {i_prog_addr[23:16] ^ 8'h5A, i_prog_addr[15:0] ^ 16'hA55A};
    assign o_rd_word = {1'b1, i_rd_word_addr} ^ 16'h5A3C;
    assign o_visibility_word = 16'hC0DE;
endmodule // cpu_side_model
`default_nettype wire

// ### sim/tb_memory_space_access_decode.sv
// self-checking bench of the memory space access decoder
`timescale 1ns/1ns
`default_nettype none
module tb_memory_space_access_decode;
    import memory_space_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic adv = 1'b0, ret = 1'b0, ld = 1'b0, special_register = 1'b0, vis = 1'b0;
    logic [22:0] target = '0;
    prog_source_type src = SRC_EXEC;
    logic [7:0] page = '0;
    logic [15:0] offset = '0, remap = '0, wold = '0, rd_word, vis_word, prog_word;
    logic [23:0] instr, prog_addr;
    data_rd_req_type rd_req = '0;
    data_wr_req_type wr_req = '0;
    wreg_load_type wload = '0;
    logic [22:0] ip;
    logic cfg, viol, rd_valid, rd_dv, rd_trap, wr_trap, w_valid;
    vector_class_type vclass;
    logic [14:0] rd_wa, wr_wa;
    logic [15:0] rd_next, rd_data, wr_data, wr_next, w_new;
    logic [1:0] strobe;
    int num_errors = 0;
    int n_checks = 0;

    // clock at 50 MHz
    always #10 i_clk = ~i_clk;

    memory_space_access_decode u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ip_advance(adv),
        .i_ip_retreat(ret), .i_ip_load(ld), .i_ip_target(target), .i_prog_source(src),
        .i_table_page_pointer(page), .i_table_offset(offset), .i_visibility_page(page),
        .i_remap_ea(remap), .i_prog_instr(instr), .i_rd_req(rd_req), .i_rd_word(rd_word),
        .i_sfr_present(special_register), .i_visibility_enable(vis), .i_visibility_word(vis_word),
        .i_wr_req(wr_req), .i_wreg_load(wload), .i_wreg_old(wold),
        .o_instruction_pointer(ip), .o_prog_addr(prog_addr), .o_prog_config_access(cfg),
        .o_prog_user_violation(viol), .o_prog_vector_class(vclass), .o_prog_word(prog_word),
        .o_rd_valid(rd_valid), .o_rd_word_addr(rd_wa), .o_rd_next_ea(rd_next),
        .o_rd_data_valid(rd_dv), .o_rd_data(rd_data), .o_rd_trap(rd_trap),
        .o_wr_word_addr(wr_wa), .o_wr_strobe(strobe), .o_wr_data(wr_data),
        .o_wr_next_ea(wr_next), .o_wr_trap(wr_trap), .o_wreg_valid(w_valid),
        .o_wreg_new(w_new));

    cpu_side_model u_cpu (.i_prog_addr(prog_addr), .i_rd_word_addr(rd_wa),
        .o_prog_instr(instr), .o_rd_word(rd_word), .o_visibility_word(vis_word));

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // pointer stepping by two in both directions
    task automatic ip_steps(input logic a, input logic r, input int n, input logic [22:0] exp);
        @(posedge i_clk);
        adv <= a;
        ret <= r;
        repeat (n) @(posedge i_clk);
        adv <= 1'b0;
        ret <= 1'b0;
        #1 check("pointer", 24'(ip), 24'(exp));
    endtask

    // jump to a target and look at the fetch address and its vector class
    task automatic vec(input logic [22:0] t, input vector_class_type c);
        logic [23:0] a;
        a = {1'b0, t[22:1], 1'b0};
        @(posedge i_clk);
        ld <= 1'b1;
        target <= t;
        @(posedge i_clk);
        ld <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 check("jump pointer", 24'(ip), a);
        check("exec addr", prog_addr, a);
        check("vector class", 24'(vclass), 24'(c));
        check("lower word", 24'(prog_word), 24'(a[15:0] ^ 16'hA55A));
    endtask

    // table and remap sources of the program address
    task automatic prog(input prog_source_type s, input logic [7:0] pg, input logic [15:0] ofs,
            input logic [15:0] ea, input logic [23:0] a, input logic c);
        logic [23:0] ins;
        ins = {a[23:16] ^ 8'h5A, a[15:0] ^ 16'hA55A};
        @(posedge i_clk);
        src <= s;
        page <= pg;
        offset <= ofs;
        remap <= ea;
        repeat (2) @(posedge i_clk);
        #1 check("prog addr", prog_addr, a);
        check("config access", 24'(cfg), 24'(c));
        check("user violation", 24'(viol), 24'h0);
        check("prog word", 24'(prog_word), 24'(a[0] ? {8'h00, ins[23:16]} : ins[15:0]));
    endtask

    // one read and one write request issued in the same cycle
    task automatic access(input logic rv, input logic rb, input logic [15:0] rea,
            input logic sp, input logic ve, input logic wv, input logic wb,
            input logic [15:0] wea, input logic [15:0] wd);
        logic [15:0] w;
        logic mis, drop;
        w = rea[15] ? (ve ? 16'hC0DE : 16'h0000) : (rea > RAM_LAST ||
            (rea <= SFR_LAST && !sp)) ? 16'h0000 : ({1'b1, rea[15:1]} ^ 16'h5A3C);
        w = rb ? {8'h00, rea[0] ? w[15:8] : w[7:0]} : w;
        mis = !wb && wea[0];
        drop = mis || wea > RAM_LAST;
        @(posedge i_clk);
        rd_req <= {rv, rb, rea};
        wr_req <= {wv, wb, wea, wd};
        special_register <= sp;
        vis <= ve;
        @(posedge i_clk);
        rd_req <= '0;
        wr_req <= '0;
        #1;
        if (rv) begin
            check("rd valid", 24'(rd_valid), 24'h1);
            check("rd word addr", 24'(rd_wa), 24'(rea[15:1]));
            check("rd next ea", 24'(rd_next), 24'(rea + (rb ? BYTE_STEP : WORD_STEP)));
        end
        if (wv) begin
            check("wr strobe", 24'(strobe), 24'(drop ? LANE_NONE : !wb ? LANE_BOTH :
                wea[0] ? LANE_HIGH : LANE_LOW));
            check("wr trap", 24'(wr_trap), 24'(mis));
            check("wr next ea", 24'(wr_next), 24'(wea + (wb ? BYTE_STEP : WORD_STEP)));
            if (!drop) begin
                check("wr word addr", 24'(wr_wa), 24'(wea[15:1]));
                check("wr data", 24'(wr_data), 24'(wb ? {wd[7:0], wd[7:0]} : wd));
            end
        end
        @(posedge i_clk);
        #1 check("wr strobe pulse", 24'(strobe), 24'h0);
        if (rv) begin
            check("rd data valid", 24'(rd_dv), 24'h1);
            check("rd data", 24'(rd_data), 24'(w));
            check("rd trap", 24'(rd_trap), 24'(!rb && rea[0]));
        end
    endtask

    // working register load with byte merge and extension
    task automatic wreg(input logic b, input extend_type e, input logic [15:0] d,
            input logic [15:0] old, input logic [15:0] exp);
        @(posedge i_clk);
        wload <= {1'b1, b, e, d};
        wold <= old;
        @(posedge i_clk);
        wload <= '0;
        #1 check("wreg valid", 24'(w_valid), 24'h1);
        check("wreg value", 24'(w_new), 24'(exp));
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        #1 check("reset addr", prog_addr, 24'h0);
        check("reset class", 24'(vclass), 24'(VEC_RESET_JUMP));
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 check("first fetch", prog_addr, RESET_JUMP_LOC);
        check("reset pointer", 24'(ip), 24'(IP_RESET_VALUE));
        ip_steps(1'b1, 1'b0, 2, 23'h000004);
        ip_steps(1'b0, 1'b1, 1, 23'h000002);
        ip_steps(1'b1, 1'b1, 1, 23'h000004);
        vec(23'h000000, VEC_RESET_JUMP);
        vec(23'h000002, VEC_RESET_TARGET);
        vec(23'h000004, VEC_PRIMARY);
        vec(23'h0000FE, VEC_PRIMARY);
        vec(23'h000100, VEC_ALTERNATE);
        vec(23'h0001FF, VEC_ALTERNATE);
        vec(23'h000200, VEC_NONE);
        vec(23'h7FFFFE, VEC_NONE);
        prog(SRC_TABLE, 8'h80, 16'h0001, 16'h0000, 24'h800001, 1'b1);
        prog(SRC_TABLE, 8'h7F, 16'hFFFE, 16'h0000, 24'h7FFFFE, 1'b0);
        prog(SRC_REMAP, 8'h12, 16'h0000, 16'h8ABC, 24'h090ABC, 1'b0);
        prog(SRC_EXEC, 8'h00, 16'h0000, 16'h0000, 24'h7FFFFE, 1'b0);
        access(1'b1, 1'b1, 16'h1001, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0803, 16'h125A);
        access(1'b1, 1'b1, 16'h1000, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0802, 16'h3477);
        access(1'b1, 1'b0, 16'h2000, 1'b1, 1'b0, 1'b1, 1'b0, 16'h2000, 16'hBEEF);
        access(1'b1, 1'b0, 16'h2001, 1'b1, 1'b0, 1'b1, 1'b0, 16'h2003, 16'h1111);
        access(1'b1, 1'b0, 16'h3FFE, 1'b1, 1'b0, 1'b1, 1'b1, 16'h4000, 16'h2222);
        access(1'b1, 1'b0, 16'h4000, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
        access(1'b1, 1'b0, 16'h0100, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100, 16'h0077);
        access(1'b1, 1'b1, 16'h07FF, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
        access(1'b1, 1'b0, 16'h8002, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
        access(1'b1, 1'b1, 16'h8003, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
        access(1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0101, 16'h00A5);
        wreg(1'b1, EXT_NONE, 16'h12AB, 16'hCD34, 16'hCDAB);
        wreg(1'b0, EXT_NONE, 16'h12AB, 16'hCD34, 16'h12AB);
        wreg(1'b0, EXT_SIGN, 16'h0000, 16'h3480, 16'hFF80);
        wreg(1'b0, EXT_SIGN, 16'h0000, 16'h347F, 16'h007F);
        wreg(1'b0, EXT_ZERO, 16'h0000, 16'hCD9A, 16'h009A);
        test_done();
    end
endmodule // tb_memory_space_access_decode
`default_nettype wire
